// >>> pkg/plc_pkg.sv
package plc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_CRC_GOOD  = 5'h12;
  localparam logic [4:0]  ADDR_EXT_MODE  = 5'h13;
  localparam logic [4:0]  ADDR_MODE_SEL  = 5'h1D;
  localparam logic [4:0]  ADDR_BEHAVIOR  = 5'h1E;
  localparam logic [4:0]  ADDR_PAGE      = 5'h1F;
  localparam logic [4:0]  ADDR_PAGE_BASE = 5'h10;

  // ----------------------------------------------------------------
  // Page select codes
  // ----------------------------------------------------------------
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT1 = 16'h0001;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  localparam logic [15:0] PAGE_GPIO = 16'h0010;
  localparam logic [15:0] PAGE_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE1_LSB     = 4;
  localparam int MODE0_LSB     = 0;
  localparam int PULSE_EN_BIT  = 12;
  localparam int RATE_LSB      = 10;
  localparam int STRETCH1_BIT  = 6;
  localparam int STRETCH0_BIT  = 5;
  localparam int COMB_DIS1_BIT = 1;
  localparam int COMB_DIS0_BIT = 0;
  localparam int EXT_MODE1_BIT = 13;
  localparam int EXT_MODE0_BIT = 12;
  localparam int CRC_FLAG_BIT  = 15;

  // ----------------------------------------------------------------
  // Values after reset, and the last count before the counter wraps
  // ----------------------------------------------------------------
  localparam logic [3:0]  MODE1_RST = 4'h5;
  localparam logic [3:0]  MODE0_RST = 4'h4;
  localparam logic [1:0]  RATE_RST  = 2'h1;
  localparam logic [13:0] CRC_LAST  = 14'h270F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 125000;
  localparam int TICK_MS      = 25;
  localparam int TICK_CYCLES  = CLK_KHZ * TICK_MS;
  localparam int PULSE_HZ     = 5000;
  localparam int PULSE_CYCLES = (CLK_KHZ * 1000) / PULSE_HZ;
  localparam int THIS_PORT    = 0;

  typedef enum logic [1:0] {
    PLC_SP_MAIN = 2'b00,
    PLC_SP_EXT1 = 2'b01,
    PLC_SP_OTHER = 2'b10
  } plc_space_t;

endpackage

// >>> hdl/plc_regs.sv
`timescale 1ns/10ps
module plc_regs #(
  parameter int TICK_CYCLES  = plc_pkg::TICK_CYCLES,
  parameter int PULSE_CYCLES = plc_pkg::PULSE_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             gpio_space_sel,
  input  wire logic        good_frame,
  input  wire logic [1:0]  ind_level,
  input  wire logic [1:0]  ind_event,
  input  wire logic [7:0]  pulse_duty,
  output logic      [3:0]  first_indicator_mode,
  output logic      [3:0]  second_indicator_mode,
  output logic             first_indicator_ext,
  output logic             second_indicator_ext,
  output logic             first_indicator_output,
  output logic             second_indicator_output
);
  import plc_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [15:0] page;
  logic [7:0]  mode_sel;
  logic        pulse_en;
  logic [1:0]  rate;
  logic [1:0]  stretch_sel;
  logic [1:0]  comb_dis;
  logic [1:0]  ext_mode;
  logic        crc_flag;
  logic [13:0] crc_count;
  plc_space_t  space;
  logic        hit_gpio;

  always_comb begin
    hit_gpio = (page == PAGE_GPIO) && (mgmt_addr != ADDR_PAGE);
    if (mgmt_addr < ADDR_PAGE_BASE || page == PAGE_MAIN) begin
      space = PLC_SP_MAIN;
    end else if (page == PAGE_EXT1) begin
      space = PLC_SP_EXT1;
    end else begin
      space = PLC_SP_OTHER;
    end
  end

  // Writes into pages that live outside this slice are dropped here.
  logic wr_main;
  logic wr_ext1;
  logic rd_crc;
  assign wr_main = mgmt_wr && !hit_gpio && space == PLC_SP_MAIN;
  assign wr_ext1 = mgmt_wr && !hit_gpio && space == PLC_SP_EXT1;
  assign rd_crc  = mgmt_rd && !hit_gpio && space == PLC_SP_EXT1
                   && mgmt_addr == ADDR_CRC_GOOD;
  assign gpio_space_sel = hit_gpio;

  // ----------------------------------------------------------------
  // Page select
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      page <= PAGE_RST;
    end else if (mgmt_wr && mgmt_addr == ADDR_PAGE) begin
      page <= mgmt_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Indicator control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_sel <= {MODE1_RST, MODE0_RST};
    end else if (wr_main && mgmt_addr == ADDR_MODE_SEL) begin
      mode_sel <= mgmt_wdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pulse_en    <= 1'b0;
      rate        <= RATE_RST;
      stretch_sel <= 2'b00;
      comb_dis    <= 2'b00;
    end else if (wr_main && mgmt_addr == ADDR_BEHAVIOR) begin
      pulse_en    <= mgmt_wdata[PULSE_EN_BIT];
      stretch_sel <= {mgmt_wdata[STRETCH1_BIT], mgmt_wdata[STRETCH0_BIT]};
      comb_dis    <= {mgmt_wdata[COMB_DIS1_BIT], mgmt_wdata[COMB_DIS0_BIT]};
      if (THIS_PORT == 0) begin
        rate <= mgmt_wdata[RATE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ext_mode <= 2'b00;
    end else if (wr_ext1 && mgmt_addr == ADDR_EXT_MODE) begin
      ext_mode <= {mgmt_wdata[EXT_MODE1_BIT], mgmt_wdata[EXT_MODE0_BIT]};
    end
  end

  assign first_indicator_mode  = mode_sel[MODE0_LSB +: 4];
  assign second_indicator_mode = mode_sel[MODE1_LSB +: 4];
  assign first_indicator_ext   = ext_mode[0];
  assign second_indicator_ext  = ext_mode[1];

  // ----------------------------------------------------------------
  // Good frame counter
  // ----------------------------------------------------------------
  // A frame landing in the read cycle is kept: it counts from zero.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      crc_count <= 14'h0000;
    end else if (good_frame) begin
      if (rd_crc) begin
        crc_count <= 14'h0001;
      end else if (crc_count == CRC_LAST) begin
        crc_count <= 14'h0000;
      end else begin
        crc_count <= crc_count + 14'h0001;
      end
    end else if (rd_crc) begin
      crc_count <= 14'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      crc_flag <= 1'b0;
    end else if (good_frame) begin
      crc_flag <= 1'b1;
    end else if (rd_crc) begin
      crc_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (mgmt_addr == ADDR_PAGE) begin
      next_rdata = page;
    end else if (hit_gpio) begin
      next_rdata = 16'h0000;
    end else if (space == PLC_SP_MAIN) begin
      case (mgmt_addr)
        ADDR_MODE_SEL: next_rdata = {8'h00, mode_sel};
        ADDR_BEHAVIOR: begin
          next_rdata[PULSE_EN_BIT]   = pulse_en;
          next_rdata[RATE_LSB +: 2]  = rate;
          next_rdata[STRETCH1_BIT]   = stretch_sel[1];
          next_rdata[STRETCH0_BIT]   = stretch_sel[0];
          next_rdata[COMB_DIS1_BIT]  = comb_dis[1];
          next_rdata[COMB_DIS0_BIT]  = comb_dis[0];
        end
        default: next_rdata = 16'h0000;
      endcase
    end else if (space == PLC_SP_EXT1) begin
      case (mgmt_addr)
        ADDR_CRC_GOOD: begin
          next_rdata[CRC_FLAG_BIT] = crc_flag;
          next_rdata[13:0]         = crc_count;
        end
        ADDR_EXT_MODE: begin
          next_rdata[EXT_MODE1_BIT] = ext_mode[1];
          next_rdata[EXT_MODE0_BIT] = ext_mode[0];
        end
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd) begin
      mgmt_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Shared time base
  // ----------------------------------------------------------------
  // One slow tick feeds every output, so all indicators blink in step.
  logic [21:0] tick_cnt;
  logic        tick;
  logic [3:0]  blink_cnt;
  logic        blink_phase;
  logic [4:0]  stretch_len;

  assign tick = (tick_cnt == 22'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!reset_n || tick) begin
      tick_cnt <= 22'h000000;
    end else begin
      tick_cnt <= tick_cnt + 22'h000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      blink_cnt <= 4'h0;
    end else if (tick) begin
      blink_cnt <= blink_cnt + 4'h1;
    end
  end

  assign blink_phase = blink_cnt[2'd3 - rate];
  assign stretch_len = 5'h02 << (2'd3 - rate);

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  logic [15:0] pwm_cnt;
  logic        pwm_on;

  always_ff @(posedge core_clk) begin
    if (!reset_n || pwm_cnt == 16'(PULSE_CYCLES - 1)) begin
      pwm_cnt <= 16'h0000;
    end else begin
      pwm_cnt <= pwm_cnt + 16'h0001;
    end
  end

  assign pwm_on = ({8'h00, pwm_cnt, 8'h00} < 32'(pulse_duty) * 32'(PULSE_CYCLES));

  // ----------------------------------------------------------------
  // Per-output indicator logic
  // ----------------------------------------------------------------
  logic [1:0] ind_out;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ind
      logic [4:0] hold;
      logic       busy;
      logic       shown;
      logic       next_out;

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          hold <= 5'h00;
        end else if (ind_event[gi]) begin
          hold <= stretch_len;
        end else if (tick && hold != 5'h00) begin
          hold <= hold - 5'h01;
        end
      end

      assign busy = ind_event[gi] || hold != 5'h00;

      always_comb begin
        if (comb_dis[gi]) begin
          shown = ind_level[gi];
        end else if (!busy) begin
          shown = ind_level[gi];
        end else if (stretch_sel[gi]) begin
          shown = !ind_level[gi];
        end else begin
          shown = blink_phase;
        end
        next_out = shown && (!pulse_en || pwm_on);
      end

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          ind_out[gi] <= 1'b0;
        end else begin
          ind_out[gi] <= next_out;
        end
      end
    end
  endgenerate

  assign first_indicator_output  = ind_out[0];
  assign second_indicator_output = ind_out[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_page_reset: assert property (@(posedge core_clk)
    !reset_n |=> page == PAGE_MAIN)
    else $error("page select not zero after reset");

  chk_mode_reset: assert property (@(posedge core_clk)
    !reset_n |=> first_indicator_mode == 4'h4 && second_indicator_mode == 4'h5)
    else $error("indicator mode defaults wrong");

  chk_crc_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
    good_frame && !rd_crc && crc_count == 14'h270F |=> crc_count == 14'h0000)
    else $error("counter did not wrap after 9999");

  chk_crc_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
    crc_count <= 14'h270F)
    else $error("counter above 9999");

  chk_crc_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    rd_crc && !good_frame |=> crc_count == 14'h0000 && !crc_flag)
    else $error("counter not cleared by read");

  chk_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    good_frame |=> crc_flag && (crc_count != $past(crc_count) || $past(rd_crc)))
    else $error("frame did not set flag and count");

  chk_read_frame: assert property (@(posedge core_clk) disable iff (!reset_n)
    rd_crc && good_frame |=> crc_flag && crc_count == 14'h0001)
    else $error("frame lost when it met a counter read");

  chk_low_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
    page == PAGE_EXT1 && mgmt_addr < ADDR_PAGE_BASE |-> space == PLC_SP_MAIN)
    else $error("low address redirected by page one");

  chk_gpio_page: assert property (@(posedge core_clk) disable iff (!reset_n)
    page == PAGE_GPIO && mgmt_wr && mgmt_addr == ADDR_MODE_SEL |=> $stable(mode_sel))
    else $error("gpio page write reached main register");

  chk_pulse_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    pulse_en && !pwm_on ##1 pulse_en |-> !first_indicator_output)
    else $error("indicator on outside pulse window");

  chk_rate_shared: assert property (@(posedge core_clk) disable iff (!reset_n)
    ind_event[0] ##1 !ind_event[0] |-> g_ind[0].hold == $past(stretch_len))
    else $error("stretch length not from shared rate");

endmodule

// >>> verif/plc_mgmt_model.sv
`timescale 1ns/10ps
module plc_mgmt_model (
  input  wire logic        core_clk,
  output logic      [4:0]  mgmt_addr,
  output logic             mgmt_wr,
  output logic             mgmt_rd,
  output logic      [15:0] mgmt_wdata,
  input  wire logic [15:0] mgmt_rdata
);
  import plc_pkg::*;
  // ----------------------------------------------------------------
  // Management controller cycles
  // ----------------------------------------------------------------
  initial begin
    mgmt_addr  = 5'h00;
    mgmt_wr    = 1'b0;
    mgmt_rd    = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // Released data is inverted so a stale value can never pass for a fresh one.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    mgmt_addr  = a;
    mgmt_wdata = d;
    mgmt_wr    = 1'b1;
    @(negedge core_clk);
    mgmt_wr    = 1'b0;
    mgmt_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge core_clk);
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    @(negedge core_clk);
    mgmt_rd   = 1'b0;
    d         = mgmt_rdata;
  endtask
  task automatic page(input logic [15:0] p);
    wr(ADDR_PAGE, p);
  endtask
endmodule

// >>> verif/tb_plc_regs.sv
`timescale 1ns/10ps
module tb_plc_regs;
  import plc_pkg::*;
  localparam int TK = 8;
  logic        core_clk, reset_n, good_frame;
  logic [4:0]  mgmt_addr;
  logic        mgmt_wr, mgmt_rd, gpio_space_sel;
  logic [15:0] mgmt_wdata, mgmt_rdata, d, v, mode_v;
  logic [1:0]  ind_level, ind_event;
  logic [7:0]  pulse_duty;
  logic [3:0]  m0, m1;
  logic        e0, e1, o0, o1, seen;
  int          err_count, n_checks, n, h, rv;

  plc_regs #(.TICK_CYCLES(TK), .PULSE_CYCLES(16)) u_plc_regs (
    .core_clk(core_clk), .reset_n(reset_n), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .gpio_space_sel(gpio_space_sel), .good_frame(good_frame), .ind_level(ind_level),
    .ind_event(ind_event), .pulse_duty(pulse_duty), .first_indicator_mode(m0),
    .second_indicator_mode(m1), .first_indicator_ext(e0), .second_indicator_ext(e1),
    .first_indicator_output(o0), .second_indicator_output(o1));
  plc_mgmt_model u_plc_mgmt_model (
    .core_clk(core_clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));

  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Expectations and comparisons
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_crc(input logic f, input int c);
    return {f, 1'b0, 14'(c % 10000)};
  endfunction
  function automatic int exp_blink(input int r);
    return (1 << (3 - r)) * TK;
  endfunction
  function automatic int exp_hold(input int r);
    return (2 << (3 - r)) * TK;
  endfunction
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected word at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected flag at %0t: got %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Back-to-back frames exercise the counter at its fastest legal rate.
  task automatic frames(input int c);
    @(negedge core_clk);
    good_frame = 1'b1;
    repeat (c) @(negedge core_clk);
    good_frame = 1'b0;
  endtask
  task automatic watch(input int c);
    seen = 1'b0;
    repeat (c) begin
      @(negedge core_clk);
      seen = seen | o0 | o1;
    end
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    print_verdict;
  end
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    good_frame = 1'b0;
    ind_level = 2'b00;
    ind_event = 2'b00;
    pulse_duty = 8'h00;
    err_count = 0;
    n_checks = 0;
    rv = $urandom(9094);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    u_plc_mgmt_model.rd(ADDR_MODE_SEL, d);
    check16(d, 16'h0054);
    u_plc_mgmt_model.rd(ADDR_BEHAVIOR, d);
    check16(d, 16'h0400);
    u_plc_mgmt_model.rd(ADDR_PAGE, d);
    check16(d, 16'h0000);
    repeat (4) begin
      v = 16'($urandom);
      mode_v = v & 16'h00FF;
      u_plc_mgmt_model.wr(ADDR_MODE_SEL, v);
      u_plc_mgmt_model.rd(ADDR_MODE_SEL, d);
      check16(d, mode_v);
      check16({8'h00, m1, m0}, mode_v);
      u_plc_mgmt_model.wr(ADDR_BEHAVIOR, v);
      u_plc_mgmt_model.rd(ADDR_BEHAVIOR, d);
      check16(d, v & 16'h1C63);
    end
    u_plc_mgmt_model.wr(ADDR_BEHAVIOR, 16'h1003);
    ind_level = 2'b11;
    watch(40);
    check_bit(seen, 1'b0);
    pulse_duty = 8'hFF;
    watch(40);
    check_bit(seen, 1'b1);
    pulse_duty = 8'h80;
    n = 0;
    repeat (32) begin
      @(negedge core_clk);
      n += o0;
    end
    check16(16'(n), 16'h0010);
    pulse_duty = 8'h00;
    u_plc_mgmt_model.wr(ADDR_BEHAVIOR, 16'h0003);
    ind_event = 2'b11;
    repeat (4) begin
      ind_level = 2'($urandom);
      repeat (3) @(negedge core_clk);
      check16({14'h0, o1, o0}, {14'h0, ind_level});
    end
    for (int r = 0; r < 4; r++) begin
      ind_level = 2'b00;
      ind_event = 2'b00;
      u_plc_mgmt_model.wr(ADDR_BEHAVIOR, 16'(r << 10) | 16'h0060);
      repeat (300) @(negedge core_clk);
      ind_event = 2'b11;
      @(negedge core_clk);
      ind_event = 2'b00;
      h = exp_hold(r);
      repeat (2) @(negedge core_clk);
      check16({14'h0, o1, o0}, 16'h0003);
      repeat (h - TK - 4) @(negedge core_clk);
      check16({14'h0, o1, o0}, 16'h0003);
      repeat (2 * TK + 6) @(negedge core_clk);
      check16({14'h0, o1, o0}, 16'h0000);
    end
    for (int r = 0; r < 4; r++) begin
      u_plc_mgmt_model.wr(ADDR_BEHAVIOR, 16'(r << 10));
      ind_event = 2'b11;
      repeat (3) @(negedge core_clk);
      seen = o0;
      while (o0 == seen) @(negedge core_clk);
      n = 0;
      seen = o0;
      while (o0 == seen) begin
        @(negedge core_clk);
        n++;
      end
      check16(16'(n), 16'(exp_blink(r)));
      check_bit(o1, o0);
    end
    ind_event = 2'b00;
    u_plc_mgmt_model.page(PAGE_EXT1);
    n = 1 + ($urandom % 60);
    frames(n);
    u_plc_mgmt_model.rd(ADDR_CRC_GOOD, d);
    check16(d, exp_crc(1'b1, n));
    u_plc_mgmt_model.rd(ADDR_CRC_GOOD, d);
    check16(d, 16'h0000);
    frames(10001);
    u_plc_mgmt_model.rd(ADDR_CRC_GOOD, d);
    check16(d, exp_crc(1'b1, 10001));
    fork
      frames(3);
      u_plc_mgmt_model.rd(ADDR_CRC_GOOD, d);
    join
    check16(d, 16'h0000);
    u_plc_mgmt_model.rd(ADDR_CRC_GOOD, d);
    check16(d, exp_crc(1'b1, 3));
    u_plc_mgmt_model.wr(ADDR_EXT_MODE, 16'hFFFF);
    u_plc_mgmt_model.rd(ADDR_EXT_MODE, d);
    check16(d, 16'h3000);
    check16({14'h0, e1, e0}, 16'h0003);
    u_plc_mgmt_model.rd(5'h15, d);
    check16(d, 16'h0000);
    u_plc_mgmt_model.rd(ADDR_MODE_SEL, d);
    check16(d, 16'h0000);
    u_plc_mgmt_model.page(PAGE_EXT2);
    u_plc_mgmt_model.wr(ADDR_EXT_MODE, 16'h0000);
    u_plc_mgmt_model.rd(ADDR_EXT_MODE, d);
    check16(d, 16'h0000);
    u_plc_mgmt_model.page(PAGE_EXT1);
    u_plc_mgmt_model.rd(ADDR_EXT_MODE, d);
    check16(d, 16'h3000);
    u_plc_mgmt_model.page(PAGE_GPIO);
    u_plc_mgmt_model.rd(5'h05, d);
    check16(d, 16'h0000);
    check_bit(gpio_space_sel, 1'b1);
    u_plc_mgmt_model.wr(ADDR_MODE_SEL, ~mode_v);
    u_plc_mgmt_model.page(PAGE_MAIN);
    check_bit(gpio_space_sel, 1'b0);
    u_plc_mgmt_model.rd(ADDR_MODE_SEL, d);
    check16(d, mode_v);
    print_verdict;
  end
endmodule
